// *** design/dcc_pkg.sv ***
package dcc_pkg;
   // ************************************************
   // Register map
   // ************************************************
   localparam logic [7:0] DCC_ADDR_CMP_A = 8'h9e;
   localparam logic [7:0] DCC_ADDR_CMP_B = 8'h9f;
   localparam logic [7:0] DCC_CTRL_RESET = 8'h00;
   localparam int DCC_BIT_ENABLE = 7;
   localparam int DCC_BIT_RESULT = 6;
   localparam int DCC_BIT_RISE = 5;
   localparam int DCC_BIT_FALL = 4;
   localparam int DCC_POS_HI = 3;
   localparam int DCC_POS_LO = 2;
   localparam int DCC_NEG_HI = 1;
   localparam int DCC_NEG_LO = 0;
   localparam int DCC_NUM_CMP = 2;
   // ************************************************
   // Hysteresis codes
   // ************************************************
   typedef enum logic [1:0] {
      DCC_HYST_OFF = 2'h0,
      DCC_HYST_2MV = 2'h1,
      DCC_HYST_4MV = 2'h2,
      DCC_HYST_10MV = 2'h3
   } dcc_hyst_t;
   localparam logic [3:0] DCC_TRIM_OFF = 4'h0;
   localparam logic [3:0] DCC_TRIM_2MV = 4'h1;
   localparam logic [3:0] DCC_TRIM_4MV = 4'h2;
   localparam logic [3:0] DCC_TRIM_10MV = 4'h4;
   // ************************************************
   // Interrupt edge selection
   // ************************************************
   localparam logic [1:0] DCC_IRQ_RISE = 2'h1;
   localparam logic [1:0] DCC_IRQ_FALL = 2'h2;
endpackage

// *** design/dcc_cmp_if.sv ***
`timescale 1ns/1ps
interface dcc_cmp_if;
   logic enable;
   logic raw;
   logic clr_rise;
   logic clr_fall;
   logic result;
   logic rise_flag;
   logic fall_flag;
   logic rise_evt;
   logic fall_evt;
   modport ctrl (output enable, output raw, output clr_rise, output clr_fall,
                 input result, input rise_flag, input fall_flag, input rise_evt, input fall_evt);
   modport chan (input enable, input raw, input clr_rise, input clr_fall,
                 output result, output rise_flag, output fall_flag, output rise_evt, output fall_evt);
endinterface

// *** design/dcc_channel.sv ***
`timescale 1ns/1ps
module dcc_channel
   import dcc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   dcc_cmp_if.chan ch
);
   // ************************************************
   // Synchroniser and edge flags
   // ************************************************
   logic sync_a;
   logic sync_b;
   logic last;
   logic arm_a;
   logic arm_b;
   logic armed;
   logic rise_flag;
   logic fall_flag;
   logic rise_evt;
   logic fall_evt;
   logic next_sync_a;
   logic next_sync_b;
   logic next_last;
   logic next_arm_a;
   logic next_arm_b;
   logic next_armed;
   logic next_rise_flag;
   logic next_fall_flag;
   logic next_rise_evt;
   logic next_fall_evt;

   always_comb begin
      next_sync_a = ch.raw;
      next_sync_b = sync_a;
      next_last = sync_b;
      // Arming waits out the synchroniser, so a core settling at power-up sets no flag
      next_arm_a = ch.enable;
      next_arm_b = ch.enable && arm_a;
      next_armed = ch.enable && arm_b;
      next_rise_evt = ch.enable && armed && sync_b && !last;
      next_fall_evt = ch.enable && armed && !sync_b && last;
      // Set beats a clear in the same cycle
      next_rise_flag = (rise_flag && !ch.clr_rise) || next_rise_evt;
      next_fall_flag = (fall_flag && !ch.clr_fall) || next_fall_evt;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         last <= 1'b0;
         arm_a <= 1'b0;
         arm_b <= 1'b0;
         armed <= 1'b0;
         rise_flag <= 1'b0;
         fall_flag <= 1'b0;
         rise_evt <= 1'b0;
         fall_evt <= 1'b0;
      end else begin
         sync_a <= next_sync_a;
         sync_b <= next_sync_b;
         last <= next_last;
         arm_a <= next_arm_a;
         arm_b <= next_arm_b;
         armed <= next_armed;
         rise_flag <= next_rise_flag;
         fall_flag <= next_fall_flag;
         rise_evt <= next_rise_evt;
         fall_evt <= next_fall_evt;
      end
   end

   assign ch.result = ch.enable & sync_b;
   assign ch.rise_flag = rise_flag;
   assign ch.fall_flag = fall_flag;
   assign ch.rise_evt = rise_evt;
   assign ch.fall_evt = fall_evt;
endmodule

// *** design/dcc_top.sv ***
`timescale 1ns/1ps
module dcc_top
   import dcc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   input wire logic [1:0] cmp_raw,
   input wire logic [1:0] cmp_open_drain,
   input wire logic [3:0] cmp_irq_sel,
   input wire logic cmp_a_reset_sel,
   output logic [1:0] cmp_power_en,
   output logic [3:0] cmp_pos_trim,
   output logic [3:0] cmp_neg_trim,
   output logic [1:0] cmp_pin_out,
   output logic [1:0] cmp_pin_oe,
   output logic [1:0] cmp_irq_req,
   output logic cmp_a_reset_req
);
   // ************************************************
   // Control fields
   // ************************************************
   logic [DCC_NUM_CMP-1:0] cmp_any_enable;
   logic [DCC_NUM_CMP-1:0][1:0] pos_hyst_sel;
   logic [DCC_NUM_CMP-1:0][1:0] neg_hyst_sel;
   logic [DCC_NUM_CMP-1:0] next_enable;
   logic [DCC_NUM_CMP-1:0][1:0] next_pos_hyst;
   logic [DCC_NUM_CMP-1:0][1:0] next_neg_hyst;
   logic [DCC_NUM_CMP-1:0] hit;
   logic [DCC_NUM_CMP-1:0][7:0] reg_view;
   logic [DCC_NUM_CMP-1:0] result;
   logic [DCC_NUM_CMP-1:0] evt_req;
   logic [DCC_NUM_CMP-1:0][3:0] pos_trim;
   logic [DCC_NUM_CMP-1:0][3:0] neg_trim;
   logic [7:0] next_rdata;
   logic [1:0] next_pin_out;
   logic [1:0] next_pin_oe;
   logic next_reset_req;

   function automatic logic [3:0] dcc_decode(input logic [1:0] sel);
      dcc_hyst_t code;
      code = dcc_hyst_t'(sel);
      unique case (code)
         DCC_HYST_OFF: dcc_decode = DCC_TRIM_OFF;
         DCC_HYST_2MV: dcc_decode = DCC_TRIM_2MV;
         DCC_HYST_4MV: dcc_decode = DCC_TRIM_4MV;
         DCC_HYST_10MV: dcc_decode = DCC_TRIM_10MV;
      endcase
   endfunction

   assign hit[0] = (sfr_addr == DCC_ADDR_CMP_A);
   assign hit[1] = (sfr_addr == DCC_ADDR_CMP_B);

   // ************************************************
   // Per-comparator channels
   // ************************************************
   genvar gi;
   generate
      for (gi = 0; gi < DCC_NUM_CMP; gi++) begin : g_cmp
         dcc_cmp_if cif ();
         assign cif.enable = cmp_any_enable[gi];
         assign cif.raw = cmp_raw[gi];
         // Writing 0 to a flag clears it; writing 1 leaves it alone
         assign cif.clr_rise = sfr_wr && hit[gi] && !sfr_wdata[DCC_BIT_RISE];
         assign cif.clr_fall = sfr_wr && hit[gi] && !sfr_wdata[DCC_BIT_FALL];
         dcc_channel u_chan (
            .sys_clk(sys_clk),
            .rst_b(rst_b),
            .ch(cif)
         );
         assign result[gi] = cif.result;
         assign reg_view[gi] = {cmp_any_enable[gi], cif.result, cif.rise_flag, cif.fall_flag,
                                pos_hyst_sel[gi], neg_hyst_sel[gi]};
         assign evt_req[gi] = (cif.rise_evt && cmp_irq_sel[2*gi]) ||
                              (cif.fall_evt && cmp_irq_sel[2*gi+1]);
         assign pos_trim[gi] = dcc_decode(pos_hyst_sel[gi]);
         assign neg_trim[gi] = dcc_decode(neg_hyst_sel[gi]);
      end
   endgenerate

   // ************************************************
   // Register writes and outputs
   // ************************************************
   always_comb begin
      next_enable = cmp_any_enable;
      next_pos_hyst = pos_hyst_sel;
      next_neg_hyst = neg_hyst_sel;
      for (int i = 0; i < DCC_NUM_CMP; i++) begin
         if (sfr_wr && hit[i]) begin
            next_enable[i] = sfr_wdata[DCC_BIT_ENABLE];
            next_pos_hyst[i] = sfr_wdata[DCC_POS_HI:DCC_POS_LO];
            next_neg_hyst[i] = sfr_wdata[DCC_NEG_HI:DCC_NEG_LO];
         end
      end
      next_rdata = sfr_rdata;
      if (sfr_rd) begin
         next_rdata = hit[0] ? reg_view[0] : (hit[1] ? reg_view[1] : 8'h00);
      end
      for (int i = 0; i < DCC_NUM_CMP; i++) begin
         // Open drain only pulls low, released high level comes from the pull-up
         next_pin_out[i] = result[i];
         next_pin_oe[i] = cmp_open_drain[i] ? !result[i] : 1'b1;
      end
      next_reset_req = cmp_a_reset_sel && result[0];
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cmp_any_enable <= '0;
         pos_hyst_sel <= '0;
         neg_hyst_sel <= '0;
         sfr_rdata <= DCC_CTRL_RESET;
         cmp_power_en <= '0;
         cmp_pos_trim <= '0;
         cmp_neg_trim <= '0;
         cmp_pin_out <= '0;
         cmp_pin_oe <= '0;
         cmp_irq_req <= '0;
         cmp_a_reset_req <= 1'b0;
      end else begin
         cmp_any_enable <= next_enable;
         pos_hyst_sel <= next_pos_hyst;
         neg_hyst_sel <= next_neg_hyst;
         sfr_rdata <= next_rdata;
         cmp_power_en <= next_enable;
         cmp_pos_trim <= pos_trim[0];
         cmp_neg_trim <= neg_trim[0];
         cmp_pin_out <= next_pin_out;
         cmp_pin_oe <= next_pin_oe;
         cmp_irq_req <= evt_req;
         cmp_a_reset_req <= next_reset_req;
      end
   end
endmodule

// *** testbench/dcc_top_asserts.sv ***
`timescale 1ns/1ps
// ************************************************
// Port checker
// ************************************************
module dcc_top_asserts
   import dcc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic [1:0] cmp_raw,
   input wire logic [1:0] cmp_open_drain,
   input wire logic [3:0] cmp_irq_sel,
   input wire logic cmp_a_reset_sel,
   input wire logic [1:0] cmp_power_en,
   input wire logic [3:0] cmp_pos_trim,
   input wire logic [3:0] cmp_neg_trim,
   input wire logic [1:0] cmp_pin_out,
   input wire logic [1:0] cmp_pin_oe,
   input wire logic [1:0] cmp_irq_req,
   input wire logic cmp_a_reset_req
);
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   AST_POWER_A: assert property (sfr_wr && sfr_addr == DCC_ADDR_CMP_A && sfr_wdata[7]
      |-> ##[1:2] cmp_power_en[0]) else $error("comparator a not powered");
   AST_PIN_LOW: assert property (!cmp_power_en[0] && !$past(cmp_power_en[0]) |-> !cmp_pin_out[0])
      else $error("disabled pin not low");
   AST_IRQ_OFF: assert property (cmp_irq_req[0] |-> $past(cmp_power_en[0], 2))
      else $error("request while disabled");
   AST_RISE_IRQ: assert property (cmp_power_en[0] && $past(cmp_power_en[0]) && cmp_irq_sel[0]
      && $rose(cmp_raw[0]) ##1 cmp_raw[0] [*3] |-> ##[0:2] cmp_irq_req[0]) else $error("rise request missing");
   AST_POS_TRIM: assert property (sfr_wr && sfr_addr == DCC_ADDR_CMP_A && sfr_wdata[3:2] == 2'h3
      |-> ##[1:2] cmp_pos_trim == DCC_TRIM_10MV) else $error("positive trim wrong");
   AST_NEG_TRIM: assert property (sfr_wr && sfr_addr == DCC_ADDR_CMP_A && sfr_wdata[1:0] == 2'h2
      |-> ##[1:2] cmp_neg_trim == DCC_TRIM_4MV) else $error("negative trim wrong");
   AST_RESET_SEL: assert property (!$past(cmp_a_reset_sel) |-> !cmp_a_reset_req)
      else $error("reset request while unselected");
   AST_OE_PP: assert property ($past(rst_b, 2) && !$past(cmp_open_drain[0]) |-> cmp_pin_oe[0])
      else $error("push-pull pin not driven");
   AST_OD_REL: assert property ($past(cmp_open_drain[0]) && cmp_pin_out[0] |-> !cmp_pin_oe[0])
      else $error("open-drain pin driven high");
endmodule
bind dcc_top dcc_top_asserts dcc_top_asserts_i (.sys_clk, .rst_b, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
   .sfr_rdata, .cmp_raw, .cmp_open_drain, .cmp_irq_sel, .cmp_a_reset_sel, .cmp_power_en, .cmp_pos_trim,
   .cmp_neg_trim, .cmp_pin_out, .cmp_pin_oe, .cmp_irq_req, .cmp_a_reset_req);

// *** testbench/dcc_analog_model.sv ***
`timescale 1ns/1ps
// ************************************************
// Comparator cores
// ************************************************
module dcc_analog_model (
   input wire logic [1:0] cmp_power_en,
   input wire logic [1:0] lvl_above,
   output logic [1:0] cmp_raw
);
   // Unpowered core holds its last decision; power-up settling not modelled
   initial begin
      cmp_raw = 2'h0;
      forever begin
         @(cmp_power_en or lvl_above);
         for (int i = 0; i < 2; i++) begin
            if (cmp_power_en[i]) begin
               cmp_raw[i] = lvl_above[i];
            end
         end
      end
   end
endmodule

// *** testbench/test_dcc_top.sv ***
`timescale 1ns/1ps
module test_dcc_top
   import dcc_pkg::*;
;
   logic sys_clk, cmp_a_reset_req;
   logic rst_b = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, cmp_a_reset_sel = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
   logic [1:0] cmp_open_drain = 2'h0, lvl_above = 2'h0, cmp_raw, cmp_power_en, cmp_pin_out, cmp_pin_oe, cmp_irq_req;
   logic [3:0] cmp_irq_sel = 4'hf, cmp_pos_trim, cmp_neg_trim;
   int error_cnt = 0;
   int n_tests = 0;
   dcc_top dcc_top_i (.sys_clk, .rst_b, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .cmp_raw,
      .cmp_open_drain, .cmp_irq_sel, .cmp_a_reset_sel, .cmp_power_en, .cmp_pos_trim, .cmp_neg_trim,
      .cmp_pin_out, .cmp_pin_oe, .cmp_irq_req, .cmp_a_reset_req);
   dcc_analog_model dcc_analog_model_i (.cmp_power_en, .lvl_above, .cmp_raw);
   // ************************************************
   // Bus and compare tasks
   // ************************************************
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge sys_clk);
      sfr_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge sys_clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge sys_clk);
      sfr_rd <= 1'b0;
      settle(1);
      chk(what, exp, sfr_rdata);
   endtask
   // Bounded: a lost edge ends the run rather than hanging it
   task automatic edge_irq(input int n, input logic lvl);
      int k;
      k = 0;
      @(posedge sys_clk);
      lvl_above[n] <= lvl;
      settle(1);
      while (cmp_irq_req[n] !== 1'b1 && k < 10) begin
         settle(1);
         k++;
      end
      chk("irq", 8'h01, {7'h0, cmp_irq_req[n]});
      if (cmp_irq_req[n] !== 1'b1) complete_run();
   endtask
   // ************************************************
   // Scenarios
   // ************************************************
   task automatic t_regs();
      rd(DCC_ADDR_CMP_A, DCC_CTRL_RESET, "ctrl a");
      rd(DCC_ADDR_CMP_B, DCC_CTRL_RESET, "ctrl b");
      wr(8'h9d, 8'hff);
      rd(8'h9d, 8'h00, "unmapped");
   endtask
   task automatic t_edges_a();
      @(posedge sys_clk);
      cmp_open_drain <= 2'h1;
      cmp_a_reset_sel <= 1'b1;
      wr(DCC_ADDR_CMP_A, 8'hce);
      settle(2);
      chk("power", 8'h01, {7'h0, cmp_power_en[0]});
      chk("trims", {DCC_TRIM_10MV, DCC_TRIM_4MV}, {cmp_pos_trim, cmp_neg_trim});
      rd(DCC_ADDR_CMP_A, 8'h8e, "no result");
      edge_irq(0, 1'b1);
      settle(2);
      chk("pins", 8'h21, {2'h0, cmp_a_reset_req, cmp_pin_oe[0], 3'h0, cmp_pin_out[0]});
      rd(DCC_ADDR_CMP_A, 8'hee, "rise");
      edge_irq(0, 1'b0);
      rd(DCC_ADDR_CMP_A, 8'hbe, "fall");
      wr(DCC_ADDR_CMP_A, 8'hbe);
      rd(DCC_ADDR_CMP_A, 8'hbe, "flags kept");
      wr(DCC_ADDR_CMP_A, 8'h8e);
      rd(DCC_ADDR_CMP_A, 8'h8e, "flags cleared");
      @(posedge sys_clk);
      cmp_open_drain <= 2'h0;
      settle(2);
      chk("push pull", 8'h01, {7'h0, cmp_pin_oe[0]});
   endtask
   task automatic t_chan_b();
      wr(DCC_ADDR_CMP_B, 8'h85);
      settle(2);
      edge_irq(1, 1'b1);
      chk("b pins", 8'h3b, {2'h0, cmp_power_en, cmp_pin_out, cmp_pin_oe});
      rd(DCC_ADDR_CMP_B, 8'he5, "ctrl b");
      chk("b reset", 8'h00, {7'h0, cmp_a_reset_req});
   endtask
   // Falling edges masked for comparator b: flag still sets, no request
   task automatic t_irq_sel();
      logic seen;
      seen = 1'b0;
      @(posedge sys_clk);
      cmp_irq_sel <= 4'h7;
      lvl_above[1] <= 1'b0;
      repeat (6) begin
         settle(1);
         seen = seen | cmp_irq_req[1];
      end
      chk("fall masked", 8'h00, {7'h0, seen});
      rd(DCC_ADDR_CMP_B, 8'hb5, "b fall");
      @(posedge sys_clk);
      cmp_irq_sel <= 4'hf;
   endtask
   task automatic t_disable();
      edge_irq(0, 1'b1);
      wr(DCC_ADDR_CMP_A, 8'h0e);
      settle(3);
      chk("pin off", 8'h00, {7'h0, cmp_pin_out[0]});
      rd(DCC_ADDR_CMP_A, 8'h0e, "disabled");
      // Unpowered core holds its old high decision and drops it at power-up
      @(posedge sys_clk);
      lvl_above[0] <= 1'b0;
      wr(DCC_ADDR_CMP_A, 8'h8e);
      settle(6);
      rd(DCC_ADDR_CMP_A, 8'h8e, "reenabled");
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_regs();
      t_edges_a();
      t_chan_b();
      t_irq_sel();
      t_disable();
      complete_run();
   end
endmodule
